// ==== rtl/control_command_port.sv ====
/*
  control command port: word-wide two-wire slave that interprets get,
  set and run commands on the device parameters, holds their power-on
  values and drives the frame-sync gpio pin.
  assumes frameSync is a one-cycle pulse from video logic on core_clk
  and that scl and sda are pins from the host, pulled up outside.
*/
// Contract
// [R1] gpio has two modes, starts disabled
// [R2] disabled mode neither drives nor samples pins
// [R3] vsync mode drives frame sync on pin
// [R4] three other gpio pins left unconnected
// [R5] only whole 16-bit words move
// [R6] answer only the fixed slave address
// [R7] commands are get, set or run
// [R8] radiometry, tlinear on, 0.01 K at power-on
// [R9] palette starts fusion, settable over port
// [R10] mode change reaches sync pin promptly
module control_command_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // two-wire link pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // frame timing from video logic
  input wire logic frameSync,
  // sync output pin
  output logic syncPinOut,
  output logic syncPinOeN,
  // the three pins with no function
  output logic [2:0] unusedPinOut,
  output logic [2:0] unusedPinOeN,
  // parameter state
  output ctrl_port_pkg::params_t params,
  // run command strobe and its function id
  output logic runStrobe,
  output logic [7:0] runId,
  // command word with an unknown op, or a get or set with an unknown id
  output logic cmdError
);

  // byte level link
  logic xferStart;
  logic xferRead;
  logic rxValid;
  logic [7:0] rxByte;
  logic txTaken;
  logic stopSeen;
  logic [7:0] txByte;
  logic engOeN;

  // word assembly and command state
  logic [7:0] hiByte_ff; // first byte of a word in flight
  logic haveHi_ff; // a high byte waits for its partner
  logic wordPhase_ff; // 0: next word is a command, 1: set data
  logic [7:0] setId_ff; // parameter id awaiting its set data
  logic [15:0] readWord_ff; // answer to the last get
  logic readLow_ff; // next read byte is the low half
  ctrl_port_pkg::params_t params_ff;
  logic [7:0] syncCnt_ff; // stretch of the sync pulse

  // answer word for a get; unknown ids read as zero
  function automatic logic [15:0] paramRead(
    input ctrl_port_pkg::params_t p,
    input logic [7:0] id
  );
    logic [15:0] v;
    v = 16'h0000;
    case (id)
      ctrl_port_pkg::ID_GPIO_MODE: v = {15'h0000, p.gpioMode};
      ctrl_port_pkg::ID_PALETTE: v = {13'h0000, p.palette};
      ctrl_port_pkg::ID_RAD_EN: v = {15'h0000, p.radEn};
      ctrl_port_pkg::ID_TLIN_EN: v = {15'h0000, p.tlinEn};
      ctrl_port_pkg::ID_TLIN_RES: v = {15'h0000, p.tlinRes};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : paramRead

  // true for an id that this port holds
  function automatic logic idKnown(input logic [7:0] id);
    return id <= ctrl_port_pkg::ID_TLIN_RES;
  endfunction : idKnown

  // the bit engine owns the wire; sdaOeN is its own flop
  two_wire_bit_engine u_engine (
    .core_clk(core_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOeN(engOeN),
    .xferStart(xferStart),
    .xferRead(xferRead),
    .rxValid(rxValid),
    .rxByte(rxByte),
    .txByte(txByte),
    .txTaken(txTaken),
    .stopSeen(stopSeen)
  );

  // open drain: the data level is always low, the enable does the work
  assign sdaOeN = engOeN;
  always_ff @(posedge core_clk) begin
    sdaOut <= 1'b0;
  end

  // [R5] bytes pair into words
  // high byte first; a lone byte at stop or restart is dropped so no
  // partial word ever reaches the interpreter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hiByte_ff <= 8'h00;
      haveHi_ff <= 1'b0;
    end else if (xferStart || stopSeen) begin
      haveHi_ff <= 1'b0;
    end else if (rxValid) begin
      hiByte_ff <= rxByte;
      haveHi_ff <= ~haveHi_ff;
    end
  end

  wire wordValid = rxValid & haveHi_ff;
  wire [15:0] word = {hiByte_ff, rxByte};
  wire [1:0] opBits = word[ctrl_port_pkg::OP_MSB:ctrl_port_pkg::OP_LSB];
  wire [7:0] cmdId = word[ctrl_port_pkg::ID_MSB:ctrl_port_pkg::ID_LSB];

  // [R7] get, set, run decode
  // the first word of a write is the command; a set takes one more
  // word as its data, further words restart as commands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wordPhase_ff <= 1'b0;
      setId_ff <= 8'h00;
      readWord_ff <= 16'h0000;
      runStrobe <= 1'b0;
      runId <= 8'h00;
      cmdError <= 1'b0;
    end else begin
      runStrobe <= 1'b0;
      cmdError <= 1'b0;
      if (xferStart && !xferRead) begin
        wordPhase_ff <= 1'b0;
      end else if (stopSeen) begin
        // a set without its data word is abandoned
        wordPhase_ff <= 1'b0;
      end else if (wordValid && wordPhase_ff) begin
        wordPhase_ff <= 1'b0;
      end else if (wordValid) begin
        case (ctrl_port_pkg::op_t'(opBits))
          ctrl_port_pkg::OP_GET: begin
            readWord_ff <= paramRead(params_ff, cmdId);
            cmdError <= ~idKnown(cmdId);
          end
          ctrl_port_pkg::OP_SET: begin
            setId_ff <= cmdId;
            wordPhase_ff <= idKnown(cmdId);
            cmdError <= ~idKnown(cmdId);
          end
          ctrl_port_pkg::OP_RUN: begin
            runStrobe <= 1'b1;
            runId <= cmdId;
          end
          default: begin
            cmdError <= 1'b1;
          end
        endcase
      end
    end
  end

  // parameter store
  // [R8] radiometric power-on values
  // [R1] gpio mode resets disabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      params_ff <= ctrl_port_pkg::PARAMS_RESET;
    end else if (wordValid && wordPhase_ff) begin
      case (setId_ff)
        // [R1] only two modes exist
        ctrl_port_pkg::ID_GPIO_MODE:
          params_ff.gpioMode <= ctrl_port_pkg::gpio_mode_t'(word[0]);
        // [R9] palette settable
        ctrl_port_pkg::ID_PALETTE:
          params_ff.palette <= ctrl_port_pkg::palette_t'(word[2:0]);
        ctrl_port_pkg::ID_RAD_EN:
          params_ff.radEn <= word[0];
        ctrl_port_pkg::ID_TLIN_EN:
          params_ff.tlinEn <= word[0];
        ctrl_port_pkg::ID_TLIN_RES:
          params_ff.tlinRes <= ctrl_port_pkg::tlin_res_t'(word[0]);
        default: begin
          // unknown ids never arm a data phase
        end
      endcase
    end
  end

  // registered copy for the output port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      params <= ctrl_port_pkg::PARAMS_RESET;
    end else begin
      params <= params_ff;
    end
  end

  // [R5] reads send whole words
  // the answer word goes out high byte then low byte, repeating while
  // the host keeps acking; each new read starts at the high byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readLow_ff <= 1'b0;
    end else if (xferStart) begin
      readLow_ff <= 1'b0;
    end else if (txTaken) begin
      readLow_ff <= ~readLow_ff;
    end
  end

  assign txByte = readLow_ff ? readWord_ff[7:0] : readWord_ff[15:8];

  // [R3] stretched frame sync
  // one clock is too short for a pin, so each frame pulse is held for
  // a fixed least width; pulses closer than that merge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncCnt_ff <= 8'h00;
    end else if (params_ff.gpioMode != ctrl_port_pkg::GPIO_VSYNC) begin
      // a pulse begun while disabled must not leak out on enable
      syncCnt_ff <= 8'h00;
    end else if (frameSync) begin
      syncCnt_ff <= 8'(ctrl_port_pkg::SYNC_PULSE_CYC);
    end else if (syncCnt_ff != 8'h00) begin
      syncCnt_ff <= syncCnt_ff - 8'h01;
    end
  end

  // [R10] mode acts next cycle
  // [R2] disabled: pin released, low
  // the mode follows the stored value at once, so a set lands well
  // before the next frame; the running pulse is cut when disabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncPinOut <= 1'b0;
      syncPinOeN <= 1'b1;
    end else if (params_ff.gpioMode == ctrl_port_pkg::GPIO_VSYNC) begin
      syncPinOut <= frameSync | (syncCnt_ff != 8'h00);
      syncPinOeN <= 1'b0;
    end else begin
      syncPinOut <= 1'b0;
      syncPinOeN <= 1'b1;
    end
  end

  // [R4] other pins never driven
  // these pins have no input path at all, so nothing ever samples them
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_unused
      always_ff @(posedge core_clk) begin
        unusedPinOut[g] <= 1'b0;
        unusedPinOeN[g] <= 1'b1;
      end
    end
  endgenerate

endmodule : control_command_port

// ==== rtl/ctrl_port_pkg.sv ====
/*
  shared constants and types for the control command port and the gpio
  mode logic: slave address, command word layout, parameter ids, reset
  values and the frame-sync pulse timing.
  assumes a single 125 MHz clock domain and a synchronous reset.
*/
package ctrl_port_pkg;

  // clock rate in MHz, used to turn times into cycle counts
  localparam int unsigned CLK_MHZ = 125;

  // fixed seven-bit two-wire slave address
  localparam logic [6:0] SLAVE_ADDR = 7'h2a;

  // command word layout: op type in the low bits, parameter id above
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OP_MSB = 1;
  localparam int unsigned ID_LSB = 8;
  localparam int unsigned ID_MSB = 15;

  // operation types carried by the command word
  typedef enum logic [1:0] {
    OP_GET = 2'h0,
    OP_SET = 2'h1,
    OP_RUN = 2'h2,
    OP_BAD = 2'h3
  } op_t;

  // parameter ids addressed by get and set
  localparam logic [7:0] ID_GPIO_MODE = 8'h00;
  localparam logic [7:0] ID_PALETTE = 8'h01;
  localparam logic [7:0] ID_RAD_EN = 8'h02;
  localparam logic [7:0] ID_TLIN_EN = 8'h03;
  localparam logic [7:0] ID_TLIN_RES = 8'h04;

  // the only two gpio modes
  typedef enum logic {
    GPIO_DISABLED = 1'b0,
    GPIO_VSYNC = 1'b1
  } gpio_mode_t;

  // built-in palettes
  typedef enum logic [2:0] {
    PAL_WHEEL6 = 3'h0,
    PAL_FUSION = 3'h1,
    PAL_RAINBOW = 3'h2,
    PAL_GLOBOW = 3'h3,
    PAL_SEPIA = 3'h4,
    PAL_COLOR = 3'h5,
    PAL_ICEFIRE = 3'h6,
    PAL_RAIN = 3'h7
  } palette_t;

  // linear temperature resolution: 0.1 K or 0.01 K per count
  typedef enum logic {
    RES_TENTH = 1'b0,
    RES_HUNDREDTH = 1'b1
  } tlin_res_t;

  // the parameter set that the port governs
  typedef struct packed {
    gpio_mode_t gpioMode;
    palette_t palette;
    logic radEn;
    logic tlinEn;
    tlin_res_t tlinRes;
  } params_t;

  // power-on values of the parameter set
  localparam params_t PARAMS_RESET = '{
    gpioMode: GPIO_DISABLED,
    palette: PAL_FUSION,
    radEn: 1'b1,
    tlinEn: 1'b1,
    tlinRes: RES_HUNDREDTH
  };

  // least width of the frame-sync pulse on the pin, in ns
  localparam int unsigned SYNC_PULSE_NS = 100;
  // the same in cycles, rounded up
  localparam int unsigned SYNC_PULSE_CYC =
    (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;

  // bit engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } link_state_t;

endpackage : ctrl_port_pkg

// ==== rtl/two_wire_bit_engine.sv ====
/*
  bit level engine of the two-wire slave: start and stop detection,
  address match, byte shifting, acknowledge generation.
  assumes scl and sda come from pins outside the clock domain and are
  slow against the 125 MHz clock; sda is open drain, pulled up outside.
*/
module two_wire_bit_engine (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pin side
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOeN,
  // byte side
  output logic xferStart,
  output logic xferRead,
  output logic rxValid,
  output logic [7:0] rxByte,
  input wire logic [7:0] txByte,
  output logic txTaken,
  output logic stopSeen
);

  // two-stage synchronisers plus a delayed copy for edge detection
  logic [1:0] sclSync_ff;
  logic [1:0] sdaSync_ff;
  logic sclDly_ff;
  logic sdaDly_ff;
  ctrl_port_pkg::link_state_t state_ff;
  logic [3:0] bitCnt_ff; // bits seen in the current byte
  logic [7:0] shift_ff;
  logic mack_ff; // master acknowledged the last sent byte

  // first stage only feeds the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      sclDly_ff <= 1'b1;
      sdaDly_ff <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      sclDly_ff <= sclSync_ff[1];
      sdaDly_ff <= sdaSync_ff[1];
    end
  end

  wire scl = sclSync_ff[1];
  wire sda = sdaSync_ff[1];
  wire sclRise = scl & ~sclDly_ff;
  wire sclFall = ~scl & sclDly_ff;
  // start and stop are sda edges while scl stays high
  wire startDet = scl & sclDly_ff & ~sda & sdaDly_ff;
  wire stopDet = scl & sclDly_ff & sda & ~sdaDly_ff;

  // byte level sequencing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ctrl_port_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      sdaOeN <= 1'b1;
      mack_ff <= 1'b0;
      xferStart <= 1'b0;
      xferRead <= 1'b0;
      rxValid <= 1'b0;
      rxByte <= 8'h00;
      txTaken <= 1'b0;
      stopSeen <= 1'b0;
    end else begin
      xferStart <= 1'b0;
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      stopSeen <= 1'b0;
      if (startDet) begin
        // start or repeated start always re-arms address phase
        state_ff <= ctrl_port_pkg::ST_ADDR;
        bitCnt_ff <= 4'h0;
        sdaOeN <= 1'b1;
      end else if (stopDet) begin
        state_ff <= ctrl_port_pkg::ST_IDLE;
        sdaOeN <= 1'b1;
        stopSeen <= 1'b1;
      end else begin
        case (state_ff)
          ctrl_port_pkg::ST_ADDR, ctrl_port_pkg::ST_RX: begin
            if (sclRise) begin
              shift_ff <= {shift_ff[6:0], sda};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == 4'h8) begin
              if (state_ff == ctrl_port_pkg::ST_RX) begin
                sdaOeN <= 1'b0;
                rxValid <= 1'b1;
                rxByte <= shift_ff;
                state_ff <= ctrl_port_pkg::ST_RX_ACK;
              // [R6] only own address acked
              end else if (shift_ff[7:1] == ctrl_port_pkg::SLAVE_ADDR) begin
                sdaOeN <= 1'b0;
                xferStart <= 1'b1;
                xferRead <= shift_ff[0];
                state_ff <= ctrl_port_pkg::ST_ADDR_ACK;
              end else begin
                // not ours: stay off the wire until the next start
                state_ff <= ctrl_port_pkg::ST_IDLE;
              end
            end
          end
          ctrl_port_pkg::ST_ADDR_ACK, ctrl_port_pkg::ST_RX_ACK: begin
            if (sclFall) begin
              bitCnt_ff <= 4'h0;
              if (state_ff == ctrl_port_pkg::ST_ADDR_ACK && xferRead) begin
                shift_ff <= txByte;
                sdaOeN <= txByte[7];
                txTaken <= 1'b1;
                state_ff <= ctrl_port_pkg::ST_TX;
              end else begin
                sdaOeN <= 1'b1;
                state_ff <= ctrl_port_pkg::ST_RX;
              end
            end
          end
          ctrl_port_pkg::ST_TX: begin
            if (sclRise) begin
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_ff == 4'h8) begin
                sdaOeN <= 1'b1;
                state_ff <= ctrl_port_pkg::ST_TX_ACK;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'b0};
                sdaOeN <= shift_ff[6];
              end
            end
          end
          ctrl_port_pkg::ST_TX_ACK: begin
            if (sclRise) begin
              mack_ff <= ~sda;
            end else if (sclFall) begin
              bitCnt_ff <= 4'h0;
              if (mack_ff) begin
                shift_ff <= txByte;
                sdaOeN <= txByte[7];
                txTaken <= 1'b1;
                state_ff <= ctrl_port_pkg::ST_TX;
              end else begin
                // master nak ends the read
                state_ff <= ctrl_port_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            sdaOeN <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : two_wire_bit_engine

// ==== verification/control_port_and_gpio_mode_bench.sv ====
/*
  self-checking bench for the control command port and gpio mode.
  assumes the bound monitor and the two-wire host model.
*/
module control_port_and_gpio_mode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst, frameSync, sclIn, sdaOut, sdaOeN, syncPinOut, syncPinOeN;
  wire sdaIn;
  logic [2:0] unusedPinOut, unusedPinOeN;
  ctrl_port_pkg::params_t params;
  logic runStrobe, cmdError, runSeen, errSeen;
  logic [7:0] runId;
  int num_errors = 0;
  int cmp_count = 0;

  // 125 MHz
  always #4 core_clk = ~core_clk;

  // unused pins go to nothing but the checks
  control_command_port u_dut (.core_clk(core_clk), .rst(rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .frameSync(frameSync), .syncPinOut(syncPinOut),
    .syncPinOeN(syncPinOeN), .unusedPinOut(unusedPinOut),
    .unusedPinOeN(unusedPinOeN), .params(params),
    .runStrobe(runStrobe), .runId(runId), .cmdError(cmdError));
  two_wire_host u_host (.core_clk(core_clk), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));

  // one-cycle strobes are latched so a task can look after the frame
  always @(posedge core_clk) begin
    if (runStrobe === 1'b1) runSeen = 1'b1;
    if (cmdError === 1'b1) errSeen = 1'b1;
  end

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic byte_out(input logic [7:0] b);
    logic a;
    u_host.put_byte(b, a);
    check("byte ack", 16'(a), 16'h0001);
  endtask : byte_out

  task automatic word_out(input logic [15:0] w);
    byte_out(w[15:8]);
    byte_out(w[7:0]);
  endtask : word_out

  // frames open with the fixed address, write direction
  task automatic frame_begin();
    u_host.start_c();
    byte_out({ctrl_port_pkg::SLAVE_ADDR, 1'b0});
  endtask : frame_begin

  task automatic frame_end();
    u_host.stop_c();
    repeat (4) @(posedge core_clk);
  endtask : frame_end

  task automatic set_param(input logic [7:0] id, input logic [15:0] v);
    frame_begin();
    word_out({id, 6'h00, ctrl_port_pkg::OP_SET});
    word_out(v);
    frame_end();
  endtask : set_param

  // get command, then repeated start and a two-byte read
  task automatic get_word(input logic [7:0] id, output logic [15:0] w);
    frame_begin();
    word_out({id, 6'h00, ctrl_port_pkg::OP_GET});
    u_host.start_c();
    byte_out({ctrl_port_pkg::SLAVE_ADDR, 1'b1});
    u_host.get_byte(1'b0, w[15:8]);
    u_host.get_byte(1'b1, w[7:0]);
    frame_end();
  endtask : get_word

  // pulse frame sync and count pin high cycles in a bounded window
  task automatic sync_count(output int n);
    @(posedge core_clk);
    frameSync <= 1'b1;
    @(posedge core_clk);
    frameSync <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge core_clk);
      if (syncPinOut === 1'b1) n++;
    end
  endtask : sync_count

  task automatic t_reset();
    check("params", 16'(params), 16'(ctrl_port_pkg::PARAMS_RESET));
    check("sync oe", 16'(syncPinOeN), 16'h0001);
    check("unused", 16'({unusedPinOeN, unusedPinOut}), 16'h0038);
  endtask : t_reset

  task automatic t_addr();
    logic a;
    u_host.start_c();
    u_host.put_byte({7'h2b, 1'b0}, a);
    check("foreign address ack", 16'(a), 16'h0000);
    u_host.stop_c();
  endtask : t_addr

  task automatic t_values();
    logic [15:0] w;
    for (int i = 2; i <= 4; i++) begin
      get_word(8'(i), w);
      check("radiometric default", w, 16'h0001);
    end
    for (int p = 0; p < 8; p++) begin
      set_param(ctrl_port_pkg::ID_PALETTE, 16'(p));
      check("palette", 16'(params.palette), 16'(p));
      get_word(ctrl_port_pkg::ID_PALETTE, w);
      check("palette get", w, 16'(p));
    end
  endtask : t_values

  task automatic t_gpio();
    int n;
    logic [15:0] w;
    set_param(ctrl_port_pkg::ID_GPIO_MODE, 16'h0001);
    check("sync oe vsync", 16'(syncPinOeN), 16'h0000);
    get_word(ctrl_port_pkg::ID_GPIO_MODE, w);
    check("gpio get", w, 16'h0001);
    sync_count(n);
    check("sync len", 16'(n), 16'(ctrl_port_pkg::SYNC_PULSE_CYC + 1));
    set_param(ctrl_port_pkg::ID_GPIO_MODE, 16'h0000);
    check("sync oe off", 16'(syncPinOeN), 16'h0001);
    sync_count(n);
    check("sync idle", 16'(n), 16'h0000);
  endtask : t_gpio

  task automatic t_cmds();
    logic [15:0] w;
    runSeen = 1'b0;
    errSeen = 1'b0;
    frame_begin();
    word_out({8'h05, 6'h00, ctrl_port_pkg::OP_RUN});
    frame_end();
    check("run strobe", 16'(runSeen), 16'h0001);
    check("run id", 16'(runId), 16'h0005);
    frame_begin();
    word_out({ctrl_port_pkg::ID_PALETTE, 6'h00, ctrl_port_pkg::OP_BAD});
    frame_end();
    check("bad op flag", 16'(errSeen), 16'h0001);
    check("palette kept", 16'(params.palette), 16'h0007);
    errSeen = 1'b0;
    get_word(8'h09, w);
    check("unknown get", w, 16'h0000);
    check("unknown flag", 16'(errSeen), 16'h0001);
  endtask : t_cmds

  // odd byte and missing data word are both dropped
  task automatic t_partial();
    frame_begin();
    word_out({ctrl_port_pkg::ID_RAD_EN, 6'h00, ctrl_port_pkg::OP_SET});
    byte_out(8'h00);
    frame_end();
    check("odd byte", 16'(params.radEn), 16'h0001);
    frame_begin();
    word_out({ctrl_port_pkg::ID_RAD_EN, 6'h00, ctrl_port_pkg::OP_SET});
    frame_end();
    check("no data word", 16'(params.radEn), 16'h0001);
    set_param(ctrl_port_pkg::ID_RAD_EN, 16'h0000);
    check("radiometry off", 16'(params.radEn), 16'h0000);
  endtask : t_partial

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    frameSync = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_addr();
    t_values();
    t_gpio();
    t_cmds();
    t_partial();
    results();
  end
endmodule : control_port_and_gpio_mode_bench

// ==== verification/control_port_monitor.sv ====
/*
  assertions on the control command port pins and parameter state.
  assumes one clock, core_clk, with a synchronous active-high rst.
*/
module control_port_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic sdaOut,
  input wire logic frameSync,
  input wire logic syncPinOut,
  input wire logic syncPinOeN,
  input wire logic [2:0] unusedPinOut,
  input wire logic [2:0] unusedPinOeN,
  // state and strobes
  input wire ctrl_port_pkg::params_t params,
  input wire logic runStrobe,
  input wire logic [7:0] runId,
  input wire logic cmdError
);
  // cycles the sync pin has stood high so far
  logic [7:0] hiCnt_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // run length counter; saturates so a stuck pin cannot wrap to a match
  always_ff @(posedge core_clk) begin
    if (rst || !syncPinOut) begin
      hiCnt_ff <= 8'h00;
    end else if (hiCnt_ff != 8'hff) begin
      hiCnt_ff <= hiCnt_ff + 8'h01;
    end
  end

  AST_RESET_VALUES: assert property (
    $fell(rst) |-> params == ctrl_port_pkg::PARAMS_RESET)
    else $error("parameters differ from power-on values");
  AST_SYNC_OE_MODE: assert property (
    syncPinOeN == (params.gpioMode != ctrl_port_pkg::GPIO_VSYNC))
    else $error("sync pin drive does not follow gpio mode");
  AST_UNUSED_IDLE: assert property (
    unusedPinOeN == 3'h7 && unusedPinOut == 3'h0)
    else $error("unused pins driven");
  AST_SDA_OPEN_DRAIN: assert property (sdaOut == 1'b0)
    else $error("data pin drives high");
  AST_SYNC_START: assert property (
    frameSync |=> syncPinOut || params.gpioMode != ctrl_port_pkg::GPIO_VSYNC)
    else $error("frame sync not passed to pin");
  AST_SYNC_WIDTH: assert property (
    $fell(syncPinOut) |-> hiCnt_ff == 8'(ctrl_port_pkg::SYNC_PULSE_CYC + 1))
    else $error("sync pulse width wrong");
  AST_SYNC_CAUSE: assert property (
    $rose(syncPinOut) |-> $past(frameSync) &&
      params.gpioMode == ctrl_port_pkg::GPIO_VSYNC)
    else $error("sync pulse without cause");
  AST_RUN_ONE_CYCLE: assert property (
    runStrobe |=> !runStrobe && $stable(runId))
    else $error("run strobe longer than one cycle");
  AST_ERR_KEEPS_PARAMS: assert property (
    cmdError |=> $stable(params) [*2])
    else $error("bad command changed parameters");

  // main scenarios reached
  cover property (runStrobe);
  cover property ($rose(syncPinOut));
  cover property (cmdError);
endmodule : control_port_monitor

bind control_command_port control_port_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .sdaOut(sdaOut), .frameSync(frameSync),
  .syncPinOut(syncPinOut), .syncPinOeN(syncPinOeN),
  .unusedPinOut(unusedPinOut), .unusedPinOeN(unusedPinOeN),
  .params(params), .runStrobe(runStrobe), .runId(runId),
  .cmdError(cmdError)
);

// ==== verification/two_wire_host.sv ====
/*
  behavioural two-wire bus master driving the control port.
  assumes an external pull-up on sda; scl idles high between frames.
*/
module two_wire_host (
  // clock
  input wire logic core_clk,
  // slave drive of the open-drain data line
  input wire logic sdaOut,
  input wire logic sdaOeN,
  // levels seen by the slave
  output logic sclIn,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // master data drive; 1 releases the line to the pull-up
  logic sdaDrv;

  // wired-and of both parties, so a released line reads high
  assign sdaIn = sdaDrv & (sdaOeN | sdaOut);

  initial begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
  end

  // one link clock phase, well above the slave's least phase
  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask : half

  // start or repeated start: sda falls while scl is high
  task automatic start_c();
    sdaDrv <= 1'b1;
    half();
    sclIn <= 1'b1;
    half();
    sdaDrv <= 1'b0;
    half();
    sclIn <= 1'b0;
    half();
  endtask : start_c

  // stop: sda rises while scl is high, then both idle
  task automatic stop_c();
    sdaDrv <= 1'b0;
    half();
    sclIn <= 1'b1;
    half();
    sdaDrv <= 1'b1;
    half();
  endtask : stop_c

  // sda changes only in scl low, sampled late in scl high
  task automatic bit_x(input logic b, output logic r);
    sdaDrv <= b;
    half();
    sclIn <= 1'b1;
    half();
    r = sdaIn;
    sclIn <= 1'b0;
    half();
  endtask : bit_x

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : put_byte

  // read a byte; nak only the last one of the answer
  task automatic get_byte(input logic last, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, q[i]);
    end
    bit_x(last, r);
  endtask : get_byte
endmodule : two_wire_host
